// ==== src/snra_addr.sv ====
`timescale 1ns/1ps
module snra_addr (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic mem_load,
	input wire logic [14:0] mem_val,
	input wire logic mem_inc,
	input wire logic reg_load,
	input wire logic [7:0] reg_val,
	input wire logic reg_inc,
	output logic [14:0] mem_addr,
	output logic [7:0] reg_addr
);
	typedef struct packed {
		logic [14:0] mem;
		logic [7:0] reg_a;
	} snra_addr_st_t;

	snra_addr_st_t a_q;
	snra_addr_st_t a_d;

	// Wrap-aware memory increment
	function automatic logic [14:0] snra_mem_next(input logic [14:0] a);
		if (a == snra_pkg::SNRA_MEM_ADDR_MAX) begin
			return snra_pkg::SNRA_MEM_ADDR_RST;
		end
		return 15'(a + 15'h0001);
	endfunction

	// ----------------------------------------------------------------
	// Two independent latches; one never touches the other
	// ----------------------------------------------------------------
	always_comb begin
		a_d = a_q;
		if (mem_load) begin
			a_d.mem = mem_val;
		end else if (mem_inc) begin
			a_d.mem = snra_mem_next(a_q.mem);
		end
		if (reg_load) begin
			a_d.reg_a = reg_val;
		end else if (reg_inc) begin
			// Past the last register the pointer rolls to zero
			a_d.reg_a = (a_q.reg_a == snra_pkg::SNRA_REG_ADDR_MAX) ?
				snra_pkg::SNRA_REG_ADDR_RST : 8'(a_q.reg_a + 8'h01);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			a_q <= '{mem: snra_pkg::SNRA_MEM_ADDR_RST, reg_a: snra_pkg::SNRA_REG_ADDR_RST};
		end else begin
			a_q <= a_d;
		end
	end

	assign mem_addr = a_q.mem;
	assign reg_addr = a_q.reg_a;
endmodule

// ==== src/snra_pkg.sv ====
package snra_pkg;

	// ----------------------------------------------------------------
	// Slave address fields, address limits, reset values and bit positions
	// ----------------------------------------------------------------
	localparam logic [3:0] SNRA_ID_MEM = 4'ha;
	localparam logic [3:0] SNRA_ID_REG = 4'hd;
	localparam logic [7:0] SNRA_REG_ADDR_MAX = 8'h18;
	localparam logic [14:0] SNRA_MEM_ADDR_MAX = 15'h7fff;
	localparam logic [14:0] SNRA_MEM_ADDR_RST = 15'h0000;
	localparam logic [7:0] SNRA_REG_ADDR_RST = 8'h00;
	localparam logic [3:0] SNRA_BIT_LAST = 4'h7;
	localparam logic [3:0] SNRA_BIT_ACK = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		SNRA_IDLE = 7'h01,
		SNRA_DEVADR = 7'h02,
		SNRA_ADRHI = 7'h04,
		SNRA_ADRLO = 7'h08,
		SNRA_WDATA = 7'h10,
		SNRA_RDATA = 7'h20,
		SNRA_IGNORE = 7'h40
	} snra_state_t;

	// Bus events from the line conditioner
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} snra_bus_ev_t;

	// Memory array and register file access
	typedef struct packed {
		logic mem_rd;
		logic mem_wr;
		logic reg_rd;
		logic reg_wr;
		logic [14:0] mem_addr;
		logic [7:0] reg_addr;
		logic [7:0] wdata;
	} snra_acc_t;

endpackage

// ==== src/snra_sync.sv ====
`timescale 1ns/1ps
module snra_sync (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output snra_pkg::snra_bus_ev_t ev
);
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_p;
		logic sda_p;
	} snra_sync_st_t;

	snra_sync_st_t s_q;
	snra_sync_st_t s_d;

	// ----------------------------------------------------------------
	// Two-stage synchronisers, then edge and condition detection
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.scl_s = {s_q.scl_s[0], scl_in};
		s_d.sda_s = {s_q.sda_s[0], sda_in};
		// Only second stage is looked at; first stage feeds it alone
		s_d.scl_p = s_q.scl_s[1];
		s_d.sda_p = s_q.sda_s[1];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			s_q <= '{scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// SDA change with SCL high marks start or stop
	assign ev.start = s_q.scl_p & s_q.scl_s[1] & s_q.sda_p & ~s_q.sda_s[1];
	assign ev.stop = s_q.scl_p & s_q.scl_s[1] & ~s_q.sda_p & s_q.sda_s[1];
	assign ev.rise = ~s_q.scl_p & s_q.scl_s[1];
	assign ev.fall = s_q.scl_p & ~s_q.scl_s[1];
	assign ev.sda = s_q.sda_s[1];
endmodule

// ==== src/snra_top.sv ====
// Functional notes
// - After read address, first data bit drives at the next SCL clock.
// - Address counter increments after every byte transferred.
// - Master acknowledge makes the device fetch and send the next byte.
// - Without proper termination the device keeps driving further data bytes.
// - Memory address wraps from the top to zero on the next read.
// - Write-direction address bytes load the memory address latch.
// - Repeated START after address acknowledge aborts the write without storing.
// - Register writes use the memory protocol with a one-byte address.
// - Register reads start at current register address and auto-increment.
// - Memory and register address latches are independent.
// - Memory read after register accesses resumes where the memory stopped.
// - Memory address is two bytes, high first; upper unused bits ignored.
// - Slave address top nibble selects memory or register device.
// - Slave address bits two and one must match the select pins.
// - Register address above the last register gets no acknowledge, aborting.
// - Master no-acknowledge ends the read and releases the bus.
`timescale 1ns/1ps
module snra_top (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_b,
	input wire logic [1:0] dev_sel,
	input wire logic mem_wide,
	output snra_pkg::snra_acc_t acc,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] reg_rdata
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		snra_pkg::snra_state_t st;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic is_reg;
		logic hi_ok;
		logic [6:0] adr_hi;
		logic drive_low;
		logic rd_nack;
		logic [1:0] sel_s0;
		logic [1:0] sel_s1;
		logic wide_s0;
		logic wide_s1;
		snra_pkg::snra_acc_t acc;
	} snra_top_st_t;

	snra_top_st_t q;
	snra_top_st_t d;
	snra_pkg::snra_bus_ev_t ev;
	logic [14:0] mem_addr;
	logic [7:0] reg_addr;
	logic mem_load;
	logic mem_inc;
	logic reg_load;
	logic reg_inc;
	logic [14:0] mem_val;
	logic [14:0] mem_eff;

	snra_sync u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ev(ev)
	);

	snra_addr u_addr (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.mem_load(mem_load),
		.mem_val(mem_val),
		.mem_inc(mem_inc),
		.reg_load(reg_load),
		.reg_val(q.sh),
		.reg_inc(reg_inc),
		.mem_addr(mem_addr),
		.reg_addr(reg_addr)
	);

	// Mask the unused high address bits for the smaller density
	function automatic logic [14:0] snra_mask(input logic [6:0] hi, input logic [7:0] lo,
		input logic wide);
		logic [14:0] a;
		a = {hi, lo};
		if (!wide) begin
			a[14:13] = 2'h0;
		end
		return a;
	endfunction

	// ----------------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		mem_load = 1'b0;
		mem_inc = 1'b0;
		reg_load = 1'b0;
		reg_inc = 1'b0;
		mem_val = snra_mask(q.adr_hi, q.sh, q.wide_s1);
		// Latch may carry stray top bits; masking here makes the small array wrap at its top
		mem_eff = snra_mask(mem_addr[14:8], mem_addr[7:0], q.wide_s1);
		d.acc.mem_rd = 1'b0;
		d.acc.mem_wr = 1'b0;
		d.acc.reg_rd = 1'b0;
		d.acc.reg_wr = 1'b0;
		// Strap-like pins come from outside, so they pass two flops
		d.sel_s0 = dev_sel;
		d.sel_s1 = q.sel_s0;
		d.wide_s0 = mem_wide;
		d.wide_s1 = q.wide_s0;
		if (ev.start) begin
			// START always aborts, so a pending write is dropped unstored
			d.st = snra_pkg::SNRA_DEVADR;
			// The SCL fall that closes START rolls this to zero before bit one
			d.bitn = 4'hf;
			d.drive_low = 1'b0;
			d.rd_nack = 1'b0;
		end else if (ev.stop) begin
			d.st = snra_pkg::SNRA_IDLE;
			d.drive_low = 1'b0;
		end else if (ev.rise) begin
			// Sample on SCL rise; the ack slot samples the master's answer
			if (q.bitn == snra_pkg::SNRA_BIT_ACK) begin
				d.rd_nack = ev.sda;
			end else if (q.st != snra_pkg::SNRA_RDATA) begin
				d.sh = {q.sh[6:0], ev.sda};
			end
		end else if (ev.fall) begin
			d.drive_low = 1'b0;
			if (q.bitn == snra_pkg::SNRA_BIT_LAST) begin
				d.bitn = snra_pkg::SNRA_BIT_ACK;
				case (q.st)
				snra_pkg::SNRA_DEVADR: begin
					if (q.sh[2:1] != q.sel_s1 ||
						(q.sh[7:4] != snra_pkg::SNRA_ID_MEM &&
						q.sh[7:4] != snra_pkg::SNRA_ID_REG)) begin
						d.st = snra_pkg::SNRA_IGNORE;
					end else begin
						d.drive_low = 1'b1;
						d.is_reg = (q.sh[7:4] == snra_pkg::SNRA_ID_REG);
						d.hi_ok = 1'b0;
						if (q.sh[0]) begin
							d.st = snra_pkg::SNRA_RDATA;
							d.acc.mem_rd = (q.sh[7:4] == snra_pkg::SNRA_ID_MEM);
							d.acc.reg_rd = (q.sh[7:4] == snra_pkg::SNRA_ID_REG);
						end else begin
							// Writes always need fresh address bytes
							d.st = (q.sh[7:4] == snra_pkg::SNRA_ID_REG) ?
								snra_pkg::SNRA_ADRLO : snra_pkg::SNRA_ADRHI;
						end
					end
				end
				snra_pkg::SNRA_ADRHI: begin
					d.adr_hi = q.sh[6:0];
					d.drive_low = 1'b1;
					d.st = snra_pkg::SNRA_ADRLO;
				end
				snra_pkg::SNRA_ADRLO: begin
					if (q.is_reg) begin
						// Reserved top bits are not checked, only the range
						if (q.sh > snra_pkg::SNRA_REG_ADDR_MAX) begin
							d.st = snra_pkg::SNRA_IGNORE;
						end else begin
							reg_load = 1'b1;
							d.drive_low = 1'b1;
							d.st = snra_pkg::SNRA_WDATA;
						end
					end else begin
						mem_load = 1'b1;
						d.drive_low = 1'b1;
						d.st = snra_pkg::SNRA_WDATA;
					end
				end
				snra_pkg::SNRA_WDATA: begin
					d.acc.wdata = q.sh;
					d.acc.mem_wr = ~q.is_reg;
					d.acc.reg_wr = q.is_reg;
					d.acc.mem_addr = mem_eff;
					d.acc.reg_addr = reg_addr;
					mem_inc = ~q.is_reg;
					reg_inc = q.is_reg;
					d.drive_low = 1'b1;
				end
				snra_pkg::SNRA_RDATA: begin
					// Bump just before the ack slot; SDA released there
					mem_inc = ~q.is_reg;
					reg_inc = q.is_reg;
				end
				default: begin
					d.st = q.st;
				end
				endcase
			end else if (q.bitn == snra_pkg::SNRA_BIT_ACK) begin
				d.bitn = 4'h0;
				if (q.st == snra_pkg::SNRA_RDATA) begin
					// Our own address ack already fetched; only a master ack fetches again
					if (q.rd_nack) begin
						d.st = snra_pkg::SNRA_IDLE;
					end else if (!q.drive_low) begin
						d.acc.mem_rd = ~q.is_reg;
						d.acc.reg_rd = q.is_reg;
					end
				end
			end else begin
				d.bitn = 4'(q.bitn + 4'h1);
				if (q.st == snra_pkg::SNRA_RDATA) begin
					d.sh = {q.sh[6:0], 1'b1};
				end
			end
		end
		if (q.acc.mem_rd || q.acc.reg_rd) begin
			// Fetched byte lands the cycle after the request
			d.sh = q.acc.mem_rd ? mem_rdata : reg_rdata;
		end
		if (d.acc.mem_rd || d.acc.reg_rd) begin
			d.acc.mem_addr = mem_eff;
			d.acc.reg_addr = reg_addr;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			q <= '{st: snra_pkg::SNRA_IDLE, bitn: 4'h0, sh: 8'h00, is_reg: 1'b0,
				hi_ok: 1'b0, adr_hi: 7'h00, drive_low: 1'b0, rd_nack: 1'b0,
				sel_s0: 2'h0, sel_s1: 2'h0, wide_s0: 1'b0, wide_s1: 1'b0,
				acc: '0};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// SDA pin: open drain, enable active low
	// ----------------------------------------------------------------
	// Read data drives only in data bits, released in the ack slot
	logic rd_drive;
	assign rd_drive = (q.st == snra_pkg::SNRA_RDATA) && (q.bitn != snra_pkg::SNRA_BIT_ACK) &&
		!q.sh[7];
	assign sda_out = 1'b0;
	assign sda_oe_b = ~(rd_drive | (q.drive_low && q.bitn == snra_pkg::SNRA_BIT_ACK));
	assign acc = q.acc;
endmodule

// ==== verif/snra_chk.sv ====
`timescale 1ns/1ps
module snra_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_b,
	input wire logic [1:0] dev_sel,
	input wire logic mem_wide,
	input wire snra_pkg::snra_acc_t acc,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] reg_rdata
);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	logic scl_q, sda_q, mseq_q, rseq_q;
	logic [14:0] mlast_q;
	logic [7:0] rlast_q;
	logic [6:0] low_q;
	wire logic bus_ev = scl_in & scl_q & (sda_in ^ sda_q);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Raw pin events run ahead of the synchroniser, which is harmless here
	always_ff @(posedge clk_sys) begin
		scl_q <= scl_in;
		sda_q <= sda_in;
		low_q <= sda_oe_b ? 7'h00 : low_q + 7'h01;
		mseq_q <= (!rst_b || bus_ev) ? 1'b0 : (mseq_q | acc.mem_rd);
		rseq_q <= (!rst_b || bus_ev) ? 1'b0 : (rseq_q | acc.reg_rd);
		mlast_q <= acc.mem_rd ? acc.mem_addr : mlast_q;
		rlast_q <= acc.reg_rd ? acc.reg_addr : rlast_q;
	end

	property p_od;
		sda_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("sda_out driven high");
	property p_rst;
		$rose(rst_b) |-> sda_oe_b && acc == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("state not cleared by reset");
	property p_one;
		$onehot0({acc.mem_rd, acc.mem_wr, acc.reg_rd, acc.reg_wr});
	endproperty
	a_one: assert property (p_one) else $error("two accesses at once");
	property p_seq;
		acc.mem_rd && mseq_q |->
			acc.mem_addr == ((mlast_q + 15'h0001) & (mem_wide ? 15'h7fff : 15'h1fff));
	endproperty
	a_seq: assert property (p_seq) else $error("memory address not stepped");
	property p_rseq;
		acc.reg_rd && rseq_q |-> acc.reg_addr == ((rlast_q == 8'h18) ? 8'h00 : rlast_q + 8'h01);
	endproperty
	a_rseq: assert property (p_rseq) else $error("register address not stepped");
	property p_narrow;
		(acc.mem_rd || acc.mem_wr) && !mem_wide && !$past(mem_wide, 4) |->
			acc.mem_addr[14:13] == 2'b00;
	endproperty
	a_narrow: assert property (p_narrow) else $error("unused address bits set");
	property p_range;
		(acc.reg_rd || acc.reg_wr) |-> acc.reg_addr <= 8'h18;
	endproperty
	a_range: assert property (p_range) else $error("register address out of range");
	property p_span;
		low_q <= 7'h4c;
	endproperty
	a_span: assert property (p_span) else $error("sda held past ack slot");
	c_mrd: cover property (acc.mem_rd && mseq_q);
	c_rrd: cover property (acc.reg_rd && rseq_q);
	c_wr: cover property (acc.mem_wr);
endmodule

bind snra_top snra_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe_b(sda_oe_b), .dev_sel(dev_sel),
	.mem_wide(mem_wide), .acc(acc), .mem_rdata(mem_rdata), .reg_rdata(reg_rdata));

// ==== verif/snra_mst.sv ====
`timescale 1ns/1ps
module snra_mst (
	output logic scl,
	output logic sda_drv,
	input wire logic sda_bus
);
	// Open drain: sda_drv low pulls the line, high lets the pull-up win
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Start or repeated start; SDA moves well clear of the SCL fall
	task automatic start();
		#50 sda_drv = 1'b1;
		#100 scl = 1'b1;
		#100 sda_drv = 1'b0;
		#100 scl = 1'b0;
	endtask
	// Stop; SCL then stands high while the bus idles
	task automatic stop();
		#50 sda_drv = 1'b0;
		#150 scl = 1'b1;
		#100 sda_drv = 1'b1;
		#100;
	endtask
	// One bit: SDA set mid-low, sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		#100 sda_drv = b;
		#100 scl = 1'b1;
		#190 r = sda_bus;
		#10 scl = 1'b0;
	endtask
endmodule

// ==== verif/snra_top_bench.sv ====
`timescale 1ns/1ps
module snra_top_bench;
	// ----------------------------------------------------------------
	// Bench wiring
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic mem_wide = 1'b1;
	logic [1:0] dev_sel = 2'b10;
	logic scl, sda_drv, sda_out, sda_oe_b;
	logic [7:0] wr_d, rg_a, rg_d;
	logic [14:0] wr_a;
	snra_pkg::snra_acc_t acc;
	int err_total = 0;
	int total_checks = 0;
	int wr_n = 0;
	wire logic sda = sda_drv & (sda_oe_b | sda_out);
	wire logic [7:0] mem_rdata = acc.mem_addr[7:0] ^ {1'b0, acc.mem_addr[14:8]};
	wire logic [7:0] reg_rdata = acc.reg_addr ^ 8'ha5;

	snra_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_b(sda_oe_b), .dev_sel(dev_sel), .mem_wide(mem_wide),
		.acc(acc), .mem_rdata(mem_rdata), .reg_rdata(reg_rdata));
	snra_mst u_mst (.scl(scl), .sda_drv(sda_drv), .sda_bus(sda));

	always #25 clk_sys = ~clk_sys;
	// Record stores so aborted writes can be told apart
	always @(posedge clk_sys) begin
		if (acc.mem_wr === 1'b1) begin
			wr_n <= wr_n + 1;
			wr_a <= acc.mem_addr;
			wr_d <= acc.wdata;
		end
		if (acc.reg_wr === 1'b1) begin
			rg_a <= acc.reg_addr;
			rg_d <= acc.wdata;
		end
	end

	task automatic finish_test();
		if (err_total == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Byte on the bus: eight bits MSB first, then the ack slot
	task automatic xb(input logic [7:0] w, input logic ma, output logic [7:0] r,
		output logic ak);
		for (int i = 7; i >= 0; i--) u_mst.bit_io(w[i], r[i]);
		u_mst.bit_io(ma, ak);
	endtask
	task automatic wb(input logic [7:0] w, input logic ea);
		logic [7:0] r;
		logic ak;
		xb(w, 1'b1, r, ak);
		chk(ak, ea);
	endtask
	task automatic ld(input logic [3:0] id, input logic [7:0] hi, input logic [7:0] lo);
		u_mst.start();
		wb({id, 1'b0, dev_sel, 1'b0}, 1'b0);
		if (id == snra_pkg::SNRA_ID_MEM) wb(hi, 1'b0);
		wb(lo, 1'b0);
	endtask
	// Read n bytes from address a; last one nacked or cut by a stop in clock nine
	task automatic rd(input logic [3:0] id, input logic [14:0] a, input int n, input bit sp);
		logic [7:0] r;
		logic ak;
		bit m;
		m = (id == snra_pkg::SNRA_ID_MEM);
		u_mst.start();
		wb({id, 1'b0, dev_sel, 1'b1}, 1'b0);
		for (int i = 0; i < n; i++) begin
			if (sp && i == n - 1) begin
				for (int k = 7; k >= 0; k--) u_mst.bit_io(1'b1, r[k]);
				u_mst.stop();
			end else begin
				xb(8'hff, i == n - 1, r, ak);
			end
			chk(r, m ? a[7:0] ^ {1'b0, a[14:8]} : a[7:0] ^ 8'ha5);
			if (m) a = (a + 15'h0001) & (mem_wide ? 15'h7fff : 15'h1fff);
			else a = (a[7:0] == 8'h18) ? 15'h0000 : a + 15'h0001;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_mem();
		int n0;
		n0 = wr_n;
		ld(snra_pkg::SNRA_ID_MEM, 8'hff, 8'hfe);
		rd(snra_pkg::SNRA_ID_MEM, 15'h7ffe, 3, 1'b0);
		rd(snra_pkg::SNRA_ID_MEM, 15'h0001, 1, 1'b1);
		chk(sda_oe_b, 1'b1);
		chk(16'(wr_n), 16'(n0));
		ld(snra_pkg::SNRA_ID_MEM, 8'h01, 8'h00);
		wb(8'h3c, 1'b0);
		wb(8'hc3, 1'b0);
		u_mst.stop();
		chk(16'(wr_n), 16'(n0 + 2));
		chk({1'b0, wr_a}, 16'h0101);
		chk(wr_d, 8'hc3);
	endtask
	task automatic t_reg();
		ld(snra_pkg::SNRA_ID_REG, 8'h00, 8'h17);
		wb(8'h5a, 1'b0);
		u_mst.stop();
		chk({rg_a, rg_d}, 16'h175a);
		ld(snra_pkg::SNRA_ID_REG, 8'h00, 8'h18);
		rd(snra_pkg::SNRA_ID_REG, 15'h0018, 2, 1'b0);
		u_mst.stop();
		rd(snra_pkg::SNRA_ID_MEM, 15'h0102, 1, 1'b0);
		u_mst.stop();
	endtask
	// Refusals, then the narrow array wrapping at its own top
	task automatic t_bad();
		u_mst.start();
		wb({4'hb, 1'b0, dev_sel, 1'b1}, 1'b1);
		u_mst.start();
		wb({snra_pkg::SNRA_ID_MEM, 1'b0, ~dev_sel, 1'b1}, 1'b1);
		u_mst.start();
		wb({snra_pkg::SNRA_ID_REG, 1'b0, dev_sel, 1'b0}, 1'b0);
		wb(8'h19, 1'b1);
		u_mst.stop();
		mem_wide = 1'b0;
		ld(snra_pkg::SNRA_ID_MEM, 8'hff, 8'hff);
		rd(snra_pkg::SNRA_ID_MEM, 15'h1fff, 2, 1'b0);
		u_mst.stop();
	endtask

	initial begin
		repeat (4) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		t_mem();
		t_reg();
		t_bad();
		finish_test();
	end
	// Whole run needs well under a third of this span
	initial begin
		#1000000;
		err_total++;
		finish_test();
	end
endmodule
